// ===== verilog/vts_map.svh
`ifndef VTS_MAP_SVH
`define VTS_MAP_SVH
// register byte offsets
`define VTS_OFF_TRIG 8'h00
`define VTS_OFF_SNIFF 8'h04
`define VTS_OFF_STAT 8'h08
`define VTS_OFF_MASK 8'h0C
`define VTS_OFF_CTRL 8'h10
// reset values
`define VTS_TRIG_RST 8'h00
`define VTS_SNIFF_RST 8'h00
// trigger mask bits
`define VTS_B_HOST 0
`define VTS_B_REMOTE 1
`define VTS_B_BOOT 2
`define VTS_B_SEEKIN 3
`define VTS_B_SEEKOUT 4
`define VTS_B_CBEGIN 5
`define VTS_B_CEND 6
`define VTS_B_UNLOCK 7
// sniff mask bits
`define VTS_B_UPLINK 0
`define VTS_B_FOREIGN 1
`define VTS_SNIFF_USED 8'h03
// status bits
`define VTS_S_START 0
`define VTS_S_REFUSED 1
`define VTS_S_SUSPEND 2
// axi responses
`define VTS_RESP_OK 2'h0
`define VTS_RESP_SLVERR 2'h2
`endif

// ===== verilog/vts_pkg.sv
package vts_pkg;
    // what started the script engine
    typedef enum logic [2:0] {
        VTS_SRC_NONE,
        VTS_SRC_HOST,
        VTS_SRC_REMOTE,
        VTS_SRC_BOOT,
        VTS_SRC_SEEKIN,
        VTS_SRC_SEEKOUT,
        VTS_SRC_CBEGIN,
        VTS_SRC_CEND
    } vts_src_t;
    typedef enum logic [1:0] {
        VTS_ENG_IDLE,
        VTS_ENG_RUN,
        VTS_ENG_HOLD
    } vts_eng_t;
    typedef struct packed {
        logic awv;
        logic [7:0] awa;
        logic wv;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic arv;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] trig;
        logic [7:0] sniff;
        logic [2:0] stat;
        logic [2:0] mask;
        logic irq;
        vts_eng_t eng;
        vts_src_t src;
        logic start;
        logic pend_remote;
        logic cend_seen;
        logic flash_ok;
        logic flash_deny;
        logic rx_accept;
    } vts_state_t;
endpackage

// ===== verilog/vts_top.sv
`timescale 1ns/1ns
`include "vts_map.svh"
module vts_top (
    input wire logic clock,
    input wire logic rst,
    // axi4-lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    output logic [1:0] bresp,
    input wire logic bready,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic rready,
    // device events, one-cycle pulses, and the mesh_sync_busy level
    input wire logic host_exec_cmd,
    input wire logic remote_exec_cmd,
    input wire logic boot_done,
    input wire logic search_enter,
    input wire logic search_exit,
    input wire logic cycle_begin,
    input wire logic cycle_end,
    input wire logic mesh_sync_busy,
    input wire logic script_done,
    input wire logic flash_op_req,
    // received packet classification
    input wire logic cmd_mode,
    input wire logic pkt_valid,
    input wire logic pkt_from_gateway,
    input wire logic pkt_is_air_cmd,
    input wire logic pkt_is_uplink,
    input wire logic pkt_addr_match,
    // outputs to the device
    output logic script_start,
    output logic [2:0] script_source,
    output logic script_running,
    output logic script_suspend,
    output logic flash_op_grant,
    output logic flash_op_deny,
    output logic pkt_accept,
    output logic irq
);

    vts_pkg::vts_state_t s_r, s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // byte-lane merge of a write into an 8-bit register
    function automatic logic [7:0] lane0(input logic [7:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] st);
        lane0 = st[0] ? d[7:0] : old;
    endfunction

    // acceptance of one received packet in command or transparent mode
    function automatic logic accept_pkt(input logic cmd,
                                        input logic gw,
                                        input logic air,
                                        input logic up,
                                        input logic match,
                                        input logic [7:0] sn);
        if (!cmd)
            accept_pkt = 1'b1;
        else if (up)
            accept_pkt = sn[`VTS_B_UPLINK];
        else if (gw && air)
            accept_pkt = match || sn[`VTS_B_FOREIGN];
        else
            accept_pkt = 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [7:0] t;
        logic fire;
        logic refused;
        vts_pkg::vts_src_t src;
        logic [2:0] ev;
        logic wr_go;
        t = s_r.trig;
        fire = 1'b0;
        refused = 1'b0;
        src = vts_pkg::VTS_SRC_NONE;
        ev = 3'h0;
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.flash_ok = 1'b0;
        s_nxt.flash_deny = 1'b0;

        // axi write: address and data taken in either order
        if (!s_r.awv && awvalid) begin
            s_nxt.awv = 1'b1;
            s_nxt.awa = awaddr;
        end
        if (!s_r.wv && wvalid) begin
            s_nxt.wv = 1'b1;
            s_nxt.wd = wdata;
            s_nxt.ws = wstrb;
        end
        wr_go = s_r.awv && s_r.wv && !s_r.bvalid;
        if (wr_go) begin
            s_nxt.awv = 1'b0;
            s_nxt.wv = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `VTS_RESP_OK;
            case (s_r.awa)
                `VTS_OFF_TRIG:
                    s_nxt.trig = lane0(s_r.trig, s_r.wd, s_r.ws);
                `VTS_OFF_SNIFF:
                    s_nxt.sniff = lane0(s_r.sniff, s_r.wd, s_r.ws)
                        & `VTS_SNIFF_USED;
                `VTS_OFF_STAT: ;
                `VTS_OFF_MASK:
                    if (s_r.ws[0])
                        s_nxt.mask = s_r.wd[2:0];
                default: s_nxt.bresp = `VTS_RESP_SLVERR;
            endcase
        end
        if (s_r.bvalid && bready)
            s_nxt.bvalid = 1'b0;

        // axi read, one at a time
        // rvalid comes from its own flop two cycles after the take
        if (!s_r.arv && !s_r.rvalid && arvalid) begin
            s_nxt.arv = 1'b1;
            s_nxt.rresp = `VTS_RESP_OK;
            case (araddr)
                `VTS_OFF_TRIG: s_nxt.rdata = {24'h000000, s_r.trig};
                `VTS_OFF_SNIFF: s_nxt.rdata = {24'h000000, s_r.sniff};
                `VTS_OFF_STAT: s_nxt.rdata = {29'h00000000, s_r.stat};
                `VTS_OFF_MASK: s_nxt.rdata = {29'h00000000, s_r.mask};
                `VTS_OFF_CTRL: s_nxt.rdata = {26'h0000000, s_r.pend_remote,
                    s_r.src, s_r.eng == vts_pkg::VTS_ENG_HOLD,
                    s_r.eng != vts_pkg::VTS_ENG_IDLE};
                default: begin
                    s_nxt.rdata = 32'h00000000;
                    s_nxt.rresp = `VTS_RESP_SLVERR;
                end
            endcase
        end
        if (s_r.arv) begin
            s_nxt.arv = 1'b0;
            s_nxt.rvalid = 1'b1;
        end
        if (s_r.rvalid && rready)
            s_nxt.rvalid = 1'b0;

        // remote execute waits for its cycle end
        if (remote_exec_cmd && t[`VTS_B_REMOTE])
            s_nxt.pend_remote = 1'b1;
        s_nxt.cend_seen = 1'b0;

        // trigger arbitration; cycle end wins over pending remote
        if (host_exec_cmd && t[`VTS_B_HOST]) begin
            fire = 1'b1;
            src = vts_pkg::VTS_SRC_HOST;
        end else if (boot_done && t[`VTS_B_BOOT]) begin
            fire = 1'b1;
            src = vts_pkg::VTS_SRC_BOOT;
        end else if (search_enter && t[`VTS_B_SEEKIN]) begin
            fire = 1'b1;
            src = vts_pkg::VTS_SRC_SEEKIN;
        end else if (search_exit && t[`VTS_B_SEEKOUT]) begin
            fire = 1'b1;
            src = vts_pkg::VTS_SRC_SEEKOUT;
        end else if (cycle_begin && t[`VTS_B_CBEGIN]) begin
            fire = 1'b1;
            src = vts_pkg::VTS_SRC_CBEGIN;
        end else if (cycle_end && t[`VTS_B_CEND]) begin
            fire = 1'b1;
            src = vts_pkg::VTS_SRC_CEND;
            if (s_r.pend_remote)
                s_nxt.cend_seen = 1'b1;
        end else if (cycle_end && s_r.pend_remote) begin
            s_nxt.cend_seen = 1'b1;
        end else if (s_r.cend_seen && s_r.eng == vts_pkg::VTS_ENG_IDLE) begin
            fire = 1'b1;
            src = vts_pkg::VTS_SRC_REMOTE;
            s_nxt.pend_remote = 1'b0;
        end else if (s_r.cend_seen) begin
            s_nxt.cend_seen = 1'b1; // held while the engine is busy, unless a host, boot, search or cycle-begin branch is taken
        end

        // engine state
        case (s_r.eng)
            vts_pkg::VTS_ENG_IDLE: begin
                if (fire) begin
                    s_nxt.eng = vts_pkg::VTS_ENG_RUN;
                    s_nxt.src = src;
                    s_nxt.start = 1'b1;
                    ev[`VTS_S_START] = 1'b1;
                end
            end
            vts_pkg::VTS_ENG_RUN: begin
                if (script_done)
                    s_nxt.eng = vts_pkg::VTS_ENG_IDLE;
                else if (mesh_sync_busy) begin
                    s_nxt.eng = vts_pkg::VTS_ENG_HOLD;
                    ev[`VTS_S_SUSPEND] = 1'b1;
                end
            end
            vts_pkg::VTS_ENG_HOLD: begin
                if (!mesh_sync_busy)
                    s_nxt.eng = vts_pkg::VTS_ENG_RUN;
            end
            default: s_nxt.eng = vts_pkg::VTS_ENG_IDLE;
        endcase

        // program flash lock
        if (flash_op_req) begin
            if (t[`VTS_B_UNLOCK])
                s_nxt.flash_ok = 1'b1;
            else begin
                s_nxt.flash_deny = 1'b1;
                refused = 1'b1;
            end
        end
        ev[`VTS_S_REFUSED] = refused;

        // packet filter
        s_nxt.rx_accept = pkt_valid && accept_pkt(cmd_mode,
            pkt_from_gateway, pkt_is_air_cmd, pkt_is_uplink,
            pkt_addr_match, s_r.sniff);

        // sticky status: a new event wins over a write-one clear
        if (wr_go && s_r.awa == `VTS_OFF_STAT && s_r.ws[0])
            s_nxt.stat = s_r.stat & ~s_r.wd[2:0];
        s_nxt.stat = s_nxt.stat | ev;
        s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
            s_r.trig <= `VTS_TRIG_RST;
            s_r.sniff <= `VTS_SNIFF_RST;
            s_r.eng <= vts_pkg::VTS_ENG_IDLE;
            s_r.src <= vts_pkg::VTS_SRC_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign awready = !s_r.awv;
    assign wready = !s_r.wv;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = !s_r.arv && !s_r.rvalid;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
    assign script_start = s_r.start;
    assign script_source = s_r.src;
    assign script_running = s_r.eng == vts_pkg::VTS_ENG_RUN;
    assign script_suspend = s_r.eng == vts_pkg::VTS_ENG_HOLD;
    assign flash_op_grant = s_r.flash_ok;
    assign flash_op_deny = s_r.flash_deny;
    assign pkt_accept = s_r.rx_accept;
    assign irq = s_r.irq;

endmodule

// ===== verification/vts_host_sva.sv
`timescale 1ns/1ns
module vts_host_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic flash_op_req,
    input wire logic flash_op_grant,
    input wire logic flash_op_deny,
    input wire logic cmd_mode,
    input wire logic pkt_valid,
    input wire logic pkt_from_gateway,
    input wire logic pkt_is_air_cmd,
    input wire logic pkt_is_uplink,
    input wire logic pkt_addr_match,
    input wire logic pkt_accept,
    input wire logic mesh_sync_busy,
    input wire logic script_done,
    input wire logic script_running,
    input wire logic script_suspend,
    input wire logic script_start,
    input wire logic [2:0] script_source
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // bus answers at fixed distance from the take
    AST_WR_RESP: assert property (awvalid && awready && wvalid && wready
        |-> ##2 bvalid) else $error("late bvalid");
    AST_RD_RESP: assert property (arvalid && arready |-> ##2 rvalid)
        else $error("late rvalid");
    // every flash request gets exactly one answer
    AST_FLASH_ANS: assert property (
        flash_op_req |=> flash_op_grant != flash_op_deny)
        else $error("flash answer");
    AST_FLASH_QUIET: assert property (
        !flash_op_req |=> !flash_op_grant && !flash_op_deny)
        else $error("stray flash answer");
    // transparent mode passes everything, own address passes unless uplink
    AST_TRANSP: assert property (
        pkt_valid && !cmd_mode |=> pkt_accept) else $error("transp drop");
    AST_OWN_ADDR: assert property (
        pkt_valid && cmd_mode && pkt_from_gateway && pkt_is_air_cmd &&
        pkt_addr_match && !pkt_is_uplink |=> pkt_accept)
        else $error("own addr drop");
    AST_HOLD: assert property (
        script_running && mesh_sync_busy && !script_done
        |=> script_suspend) else $error("no hold");
    AST_START: assert property (
        script_start |-> script_source != 3'h0 ##1 !script_start)
        else $error("bad start pulse");
endmodule
bind vts_top vts_host_sva i_vts_host_sva (.clock, .rst, .awvalid,
    .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid,
    .flash_op_req, .flash_op_grant, .flash_op_deny, .cmd_mode, .pkt_valid,
    .pkt_from_gateway, .pkt_is_air_cmd, .pkt_is_uplink, .pkt_addr_match,
    .pkt_accept, .mesh_sync_busy, .script_done, .script_running,
    .script_suspend, .script_start, .script_source);

// ===== verification/vts_mesh_model.sv
`timescale 1ns/1ns
module vts_mesh_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic script_start,
    input wire logic script_suspend,
    input wire logic [3:0] lat,
    output logic script_done
);
    logic [3:0] cnt_r;
    logic busy_r;
    // script ends lat+2 cycles after start; a held one makes no progress
    always_ff @(posedge clock) begin
        script_done <= 1'b0;
        if (rst) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
        end else if (script_start) begin
            busy_r <= 1'b1;
            cnt_r <= lat;
        end else if (busy_r && !script_suspend) begin
            busy_r <= cnt_r != 4'h0;
            script_done <= cnt_r == 4'h0;
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`include "vts_map.svh"
module tb_top;
    logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, mesh_sync_busy, script_done;
    logic flash_op_req, cmd_mode, pkt_valid, pkt_from_gateway, irq;
    logic pkt_is_air_cmd, pkt_is_uplink, pkt_addr_match, script_start;
    logic script_running, script_suspend, flash_op_grant, flash_op_deny;
    logic pkt_accept;
    logic [7:0] awaddr, araddr, ev;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb, lat;
    logic [1:0] bresp, rresp, r;
    logic [2:0] script_source;
    logic [7:0] tbl [8] = '{8'h82, 8'h12, 8'h9D, 8'h1C, 8'h98, 8'hB2,
        8'hDC, 8'h52};
    int err_total, compares, i;
    vts_top i_vts_top (.clock, .rst, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bresp, .bready, .arvalid,
        .arready, .araddr, .rvalid, .rdata, .rresp, .rready,
        .host_exec_cmd(ev[0]), .remote_exec_cmd(ev[1]), .boot_done(ev[2]),
        .search_enter(ev[3]), .search_exit(ev[4]), .cycle_begin(ev[5]),
        .cycle_end(ev[6]), .mesh_sync_busy, .script_done, .flash_op_req,
        .cmd_mode, .pkt_valid, .pkt_from_gateway, .pkt_is_air_cmd,
        .pkt_is_uplink, .pkt_addr_match, .script_start, .script_source,
        .script_running, .script_suspend, .flash_op_grant, .flash_op_deny,
        .pkt_accept, .irq);
    vts_mesh_model i_vts_mesh_model (.clock, .rst, .script_start,
        .script_suspend, .lat, .script_done);
    // 25 MHz
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic tally_and_finish;
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // a wait that runs out ends the run
    task automatic tmo;
        err_total++;
        $display("BAD %0t wait ran out", $time);
        tally_and_finish();
    endtask
    // each channel is released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 30 && !(bvalid === 1'b1); n++) begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        if (n == 30) tmo();
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 30 && !(rvalid === 1'b1); n++) begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end
        if (n == 30) tmo();
        {v, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task automatic pulse(input int k);
        @(posedge clock);
        ev <= 8'h01 << k;
        @(posedge clock);
        ev <= 8'h00;
    endtask
    task automatic wait_start(input logic [2:0] s);
        int n;
        #1;
        for (n = 0; n < 30 && script_start !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        if (n == 30) tmo();
        chk(script_source, s, "source");
    endtask
    task automatic no_start;
        repeat (6) begin
            @(posedge clock);
            #1;
            chk(script_start, 1'b0, "start");
        end
    endtask
    task automatic flash(input logic g);
        @(posedge clock);
        flash_op_req <= 1'b1;
        @(posedge clock);
        flash_op_req <= 1'b0;
        #1;
        chk({flash_op_grant, flash_op_deny}, {g, !g}, "flash");
    endtask
    // sniff value, mode and qualifiers from one table entry
    task automatic pkt(input logic [7:0] t);
        wr(`VTS_OFF_SNIFF, {30'h0, t[6:5]});
        @(posedge clock);
        {cmd_mode, pkt_from_gateway, pkt_is_air_cmd, pkt_is_uplink,
            pkt_addr_match} <= t[4:0];
        pkt_valid <= 1'b1;
        @(posedge clock);
        pkt_valid <= 1'b0;
        #1;
        chk(pkt_accept, t[7], "accept");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {mesh_sync_busy, flash_op_req, cmd_mode, pkt_valid} = 4'h0;
        {pkt_from_gateway, pkt_is_air_cmd, pkt_is_uplink} = 3'h0;
        {pkt_addr_match, ev, awaddr, araddr, wdata} = 57'h0;
        {wstrb, lat, err_total, compares} = 72'h0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        // trig reset value, unmapped place, unused sniff bits
        rd(`VTS_OFF_TRIG);
        chk(v, 32'h0, "trig rst");
        wr(8'h20, 32'hFF);
        chk(r, `VTS_RESP_SLVERR, "wr unmapped");
        rd(8'h20);
        chk(r, `VTS_RESP_SLVERR, "rd unmapped resp");
        chk(v, 32'h0, "rd unmapped data");
        wr(`VTS_OFF_SNIFF, 32'hFF);
        rd(`VTS_OFF_SNIFF);
        chk(v, 32'h3, "sniff");
        // each trigger except remote alone starts the engine, its absence does not
        for (i = 0; i < 7; i++) begin
            if (i == 1) continue;
            wr(`VTS_OFF_TRIG, 32'h7D & ~(32'h1 << i));
            pulse(i);
            no_start();
            wr(`VTS_OFF_TRIG, 32'h1 << i);
            pulse(i);
            wait_start(3'(i + 1));
            repeat (8) @(posedge clock);
        end
        // remote run waits for cycle end, cycle-end script first
        lat <= 4'h6;
        wr(`VTS_OFF_TRIG, 32'h42);
        pulse(1);
        no_start();
        pulse(6);
        wait_start(3'h7);
        @(posedge clock);
        wait_start(3'h2);
        repeat (12) @(posedge clock);
        // held while the mesh does timing work
        wr(`VTS_OFF_TRIG, 32'h01);
        pulse(0);
        wait_start(3'h1);
        @(posedge clock);
        mesh_sync_busy <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk(script_suspend, 1'b1, "held");
        @(posedge clock);
        mesh_sync_busy <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk({script_suspend, script_running}, 2'h1, "resumed");
        repeat (12) @(posedge clock);
        // refusal sets a sticky bit; irq masked, unmasked, cleared
        wr(`VTS_OFF_STAT, 32'h7);
        wr(`VTS_OFF_MASK, 32'h0);
        wr(`VTS_OFF_TRIG, 32'h0);
        flash(1'b0);
        chk(irq, 1'b0, "irq masked");
        rd(`VTS_OFF_STAT);
        chk(v, 32'h2, "refused");
        wr(`VTS_OFF_MASK, 32'h2);
        @(posedge clock);
        #1;
        chk(irq, 1'b1, "irq");
        wr(`VTS_OFF_STAT, 32'h2);
        @(posedge clock);
        #1;
        chk(irq, 1'b0, "irq clear");
        wr(`VTS_OFF_TRIG, 32'h80);
        flash(1'b1);
        // acceptance table: transparent, own address, sniff bits
        foreach (tbl[k]) pkt(tbl[k]);
        tally_and_finish();
    end
endmodule
